// ### rtl/rpa_cfg.svh
// offsets, field positions, reset values and timing constants of the record path registers
`ifndef RPA_CFG_SVH
`define RPA_CFG_SVH

// register offsets on the page-0 register port
`define RPA_OFF_ROUTE 7'h18
`define RPA_OFF_BIAS 7'h19
`define RPA_OFF_AGC_A 7'h1A
`define RPA_OFF_AGC_B 7'h1B
`define RPA_OFF_AGC_C 7'h1C

// field positions
`define RPA_ROUTE_DIFF_BIT 7
`define RPA_ROUTE_LVL_HI 6
`define RPA_ROUTE_LVL_LO 3
`define RPA_BIAS_HI 7
`define RPA_BIAS_LO 6
`define RPA_AGC_EN_BIT 7
`define RPA_TARGET_HI 6
`define RPA_TARGET_LO 4
`define RPA_ATTACK_HI 3
`define RPA_ATTACK_LO 2
`define RPA_DECAY_HI 1
`define RPA_DECAY_LO 0
`define RPA_MAXG_HI 7
`define RPA_MAXG_LO 1
`define RPA_MAXG_RSVD_BIT 0
`define RPA_HYST_HI 7
`define RPA_HYST_LO 6
`define RPA_NOISE_HI 5
`define RPA_NOISE_LO 1
`define RPA_CLIP_BIT 0

// reset values
`define RPA_RST_ROUTE_DIFF 1'h0
`define RPA_RST_ROUTE_LVL 4'hF
`define RPA_RST_BIAS 2'h0
`define RPA_RST_AGC_EN 1'h0
`define RPA_RST_TARGET 3'h0
`define RPA_RST_ATTACK 2'h0
`define RPA_RST_DECAY 2'h0
`define RPA_RST_MAXG 7'h7F
`define RPA_RST_MAXG_RSVD 1'h0
`define RPA_RST_HYST 2'h0
`define RPA_RST_NOISE 5'h00
`define RPA_RST_CLIP 1'h0

// input level codes
`define RPA_LVL_MAX_GAIN 4'h8
`define RPA_LVL_OFF 4'hF

// maximum gain saturation, in 0.5 dB steps (59.5 dB)
`define RPA_MAXG_CAP 7'h77

// time constants in ms
`define RPA_ATTACK_MS_0 10'd8
`define RPA_ATTACK_MS_1 10'd11
`define RPA_ATTACK_MS_2 10'd16
`define RPA_ATTACK_MS_3 10'd20
`define RPA_DECAY_MS_0 10'd100
`define RPA_DECAY_MS_1 10'd200
`define RPA_DECAY_MS_2 10'd400
`define RPA_DECAY_MS_3 10'd500

// clock rate and derived cycles per ms (200 MHz)
`define RPA_CLOCK_KHZ 200000
`define RPA_CYCLES_PER_MS (`RPA_CLOCK_KHZ)

// gain steps taken within one programmed time constant
`define RPA_STEPS_PER_CONST 32'd64

// noise threshold in 0.5 dB attenuation: 56 + 4 * code
`define RPA_NOISE_BASE 8'd56
`define RPA_NOISE_SCALE 2

`endif

// ### rtl/rpa_pkg.sv
// types of the record path configuration block
package rpa_pkg;

	typedef enum logic [1:0] {
		RPA_BIAS_OFF = 2'h0,
		RPA_BIAS_2V0 = 2'h1,
		RPA_BIAS_2V5 = 2'h2,
		RPA_BIAS_SUPPLY = 2'h3
	} rpa_bias_t;

	typedef struct packed {
		logic differential;
		logic connected;
		logic [3:0] atten_steps;
	} rpa_route_t;

	typedef struct packed {
		logic enable;
		logic [2:0] target;
		logic [1:0] attack;
		logic [1:0] decay;
		logic [6:0] max_gain;
		logic [1:0] hyst;
		logic [4:0] noise_thr;
		logic clip_step;
	} rpa_agc_cfg_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} rpa_reg_req_t;

	typedef enum logic [1:0] {
		RPA_AGC_IDLE,
		RPA_AGC_TRACK,
		RPA_AGC_GATED
	} rpa_agc_state_t;

endpackage : rpa_pkg

// ### rtl/rpa_agc_core.sv
// left-channel gain control engine driven by the configuration fields
`timescale 1ns/1ps
`include "rpa_cfg.svh"

module rpa_agc_core #(
	parameter int unsigned P_CYCLES_PER_MS = `RPA_CYCLES_PER_MS
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// configuration
	input wire rpa_pkg::rpa_agc_cfg_t i_cfg,
	input wire logic i_double_rate_audio,
	// measured level, attenuation below full scale in 0.5 dB steps
	input wire logic i_level_valid,
	input wire logic [7:0] i_level_atten,
	input wire logic i_clip,
	// applied gain in 0.5 dB steps
	output logic [6:0] o_gain,
	output logic o_gated
);

	typedef struct packed {
		rpa_pkg::rpa_agc_state_t fsm;
		logic [6:0] gain;
		logic [31:0] cnt;
		logic [7:0] level;
	} rpa_agc_st_t;

	rpa_agc_st_t st;
	rpa_agc_st_t next_st;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] target_atten(input logic [2:0] code);
		case (code)
			3'h0: target_atten = 8'd11;
			3'h1: target_atten = 8'd16;
			3'h2: target_atten = 8'd20;
			3'h3: target_atten = 8'd24;
			3'h4: target_atten = 8'd28;
			3'h5: target_atten = 8'd34;
			3'h6: target_atten = 8'd40;
			default: target_atten = 8'd48;
		endcase
	endfunction : target_atten

	// interval between single 0.5 dB steps; halved under double-rate audio
	function automatic logic [31:0] step_cycles(input logic [9:0] ms, input logic double_rate_audio);
		logic [31:0] c;
		c = (32'(ms) * 32'(P_CYCLES_PER_MS)) / `RPA_STEPS_PER_CONST;
		if (double_rate_audio) begin
			c = c >> 1;
		end
		if (c == 32'h0) begin
			c = 32'h1;
		end
		step_cycles = c;
	endfunction : step_cycles

	logic [9:0] attack_ms;
	logic [9:0] decay_ms;
	logic [6:0] cap;
	logic [7:0] noise_atten;
	logic [7:0] hyst_atten;
	logic loud;
	logic [31:0] interval;

	always_comb begin
		case (i_cfg.attack)
			2'h0: attack_ms = `RPA_ATTACK_MS_0;
			2'h1: attack_ms = `RPA_ATTACK_MS_1;
			2'h2: attack_ms = `RPA_ATTACK_MS_2;
			default: attack_ms = `RPA_ATTACK_MS_3;
		endcase
		case (i_cfg.decay)
			2'h0: decay_ms = `RPA_DECAY_MS_0;
			2'h1: decay_ms = `RPA_DECAY_MS_1;
			2'h2: decay_ms = `RPA_DECAY_MS_2;
			default: decay_ms = `RPA_DECAY_MS_3;
		endcase
		case (i_cfg.hyst)
			2'h0: hyst_atten = 8'd2;
			2'h1: hyst_atten = 8'd4;
			2'h2: hyst_atten = 8'd6;
			default: hyst_atten = 8'd0;
		endcase
		cap = (i_cfg.max_gain > `RPA_MAXG_CAP) ? `RPA_MAXG_CAP : i_cfg.max_gain;
		noise_atten = `RPA_NOISE_BASE + {1'b0, i_cfg.noise_thr, 2'b00};
		loud = st.level < target_atten(i_cfg.target);
		interval = loud ? step_cycles(attack_ms, i_double_rate_audio)
			: step_cycles(decay_ms, i_double_rate_audio);
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		if (i_level_valid) begin
			next_st.level = i_level_atten;
		end
		case (st.fsm)
			rpa_pkg::RPA_AGC_IDLE: begin
				next_st.gain = 7'h00;
				next_st.cnt = 32'h0;
				if (i_cfg.enable) begin
					next_st.fsm = rpa_pkg::RPA_AGC_TRACK;
				end
			end
			rpa_pkg::RPA_AGC_TRACK: begin
				if (st.cnt >= interval - 32'h1) begin
					next_st.cnt = 32'h0;
					if (loud && st.gain != 7'h00) begin
						next_st.gain = st.gain - 7'h01;
					end else if (!loud && st.gain < cap) begin
						next_st.gain = st.gain + 7'h01;
					end
				end else begin
					next_st.cnt = st.cnt + 32'h1;
				end
				if (i_cfg.noise_thr != 5'h00 && st.level > noise_atten) begin
					next_st.fsm = rpa_pkg::RPA_AGC_GATED;
					next_st.cnt = 32'h0;
					next_st.gain = st.gain;
				end
			end
			rpa_pkg::RPA_AGC_GATED: begin
				next_st.cnt = 32'h0;
				if (i_cfg.noise_thr == 5'h00 || 9'(st.level) + 9'(hyst_atten) < 9'(noise_atten)) begin
					next_st.fsm = rpa_pkg::RPA_AGC_TRACK;
				end
			end
			default: begin
				next_st.fsm = rpa_pkg::RPA_AGC_IDLE;
			end
		endcase
		if (i_cfg.clip_step && i_clip && next_st.gain != 7'h00) begin
			next_st.gain = next_st.gain - 7'h01;
		end
		if (next_st.gain > cap) begin
			next_st.gain = cap;
		end
		// a disabled channel drops its gain at once instead of holding a stale boost
		if (!i_cfg.enable) begin
			next_st.fsm = rpa_pkg::RPA_AGC_IDLE;
			next_st.gain = 7'h00;
			next_st.cnt = 32'h0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st <= '{fsm: rpa_pkg::RPA_AGC_IDLE, gain: 7'h00, cnt: 32'h0, level: 8'hFF};
		end else begin
			st <= next_st;
		end
	end

	assign o_gain = st.gain;
	assign o_gated = (st.fsm == rpa_pkg::RPA_AGC_GATED);

endmodule : rpa_agc_core

// ### rtl/rpa_regs.sv
// record path routing, mic bias and left gain control configuration registers
`timescale 1ns/1ps
`include "rpa_cfg.svh"

module rpa_regs #(
	parameter int unsigned P_CYCLES_PER_MS = `RPA_CYCLES_PER_MS
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// register port from the control bus logic
	input wire rpa_pkg::rpa_reg_req_t i_req,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// record path status inputs
	input wire logic i_double_rate_audio,
	input wire logic i_level_valid,
	input wire logic [7:0] i_level_atten,
	input wire logic i_clip,
	// analog controls
	output rpa_pkg::rpa_route_t o_route,
	output rpa_pkg::rpa_bias_t o_mic_bias,
	output rpa_pkg::rpa_agc_cfg_t o_agc_cfg,
	// gain control result
	output logic [6:0] o_agc_gain,
	output logic o_agc_gated
);

	typedef struct packed {
		logic route_diff;
		logic [3:0] route_lvl;
		logic [1:0] bias;
		logic agc_en;
		logic [2:0] target;
		logic [1:0] attack;
		logic [1:0] decay;
		logic [6:0] max_gain;
		logic max_rsvd;
		logic [1:0] hyst;
		logic [4:0] noise_thr;
		logic clip_step;
		logic [7:0] rdata;
		logic rvalid;
	} rpa_regs_st_t;

	rpa_regs_st_t st;
	rpa_regs_st_t next_st;

	////////////////////////////////////////////////////////////////////////////////
	// read image of one register; unmapped offsets read zero
	function automatic logic [7:0] read_image(input rpa_regs_st_t s, input logic [6:0] addr);
		logic [7:0] d;
		d = 8'h00;
		case (addr)
			`RPA_OFF_ROUTE: begin
				d[`RPA_ROUTE_DIFF_BIT] = s.route_diff;
				d[`RPA_ROUTE_LVL_HI:`RPA_ROUTE_LVL_LO] = s.route_lvl;
			end
			`RPA_OFF_BIAS: begin
				d[`RPA_BIAS_HI:`RPA_BIAS_LO] = s.bias;
			end
			`RPA_OFF_AGC_A: begin
				d[`RPA_AGC_EN_BIT] = s.agc_en;
				d[`RPA_TARGET_HI:`RPA_TARGET_LO] = s.target;
				d[`RPA_ATTACK_HI:`RPA_ATTACK_LO] = s.attack;
				d[`RPA_DECAY_HI:`RPA_DECAY_LO] = s.decay;
			end
			`RPA_OFF_AGC_B: begin
				d[`RPA_MAXG_HI:`RPA_MAXG_LO] = s.max_gain;
				d[`RPA_MAXG_RSVD_BIT] = s.max_rsvd;
			end
			`RPA_OFF_AGC_C: begin
				d[`RPA_HYST_HI:`RPA_HYST_LO] = s.hyst;
				d[`RPA_NOISE_HI:`RPA_NOISE_LO] = s.noise_thr;
				d[`RPA_CLIP_BIT] = s.clip_step;
			end
			default: begin
				d = 8'h00;
			end
		endcase
		read_image = d;
	endfunction : read_image

	// reserved codes and the off code 4'hF connect nothing; codes 0 to 8 connect the input
	function automatic logic level_connects(input logic [3:0] code);
		level_connects = (code <= `RPA_LVL_MAX_GAIN);
	endfunction : level_connects

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.rvalid = i_req.rd;
		if (i_req.rd) begin
			next_st.rdata = read_image(st, i_req.addr);
		end
		if (i_req.wr) begin
			case (i_req.addr)
				`RPA_OFF_ROUTE: begin
					next_st.route_diff = i_req.wdata[`RPA_ROUTE_DIFF_BIT];
					next_st.route_lvl = i_req.wdata[`RPA_ROUTE_LVL_HI:`RPA_ROUTE_LVL_LO];
				end
				`RPA_OFF_BIAS: begin
					next_st.bias = i_req.wdata[`RPA_BIAS_HI:`RPA_BIAS_LO];
				end
				`RPA_OFF_AGC_A: begin
					next_st.agc_en = i_req.wdata[`RPA_AGC_EN_BIT];
					next_st.target = i_req.wdata[`RPA_TARGET_HI:`RPA_TARGET_LO];
					next_st.attack = i_req.wdata[`RPA_ATTACK_HI:`RPA_ATTACK_LO];
					next_st.decay = i_req.wdata[`RPA_DECAY_HI:`RPA_DECAY_LO];
				end
				`RPA_OFF_AGC_B: begin
					next_st.max_gain = i_req.wdata[`RPA_MAXG_HI:`RPA_MAXG_LO];
					next_st.max_rsvd = i_req.wdata[`RPA_MAXG_RSVD_BIT];
				end
				`RPA_OFF_AGC_C: begin
					next_st.hyst = i_req.wdata[`RPA_HYST_HI:`RPA_HYST_LO];
					next_st.noise_thr = i_req.wdata[`RPA_NOISE_HI:`RPA_NOISE_LO];
					next_st.clip_step = i_req.wdata[`RPA_CLIP_BIT];
				end
				default: begin
					next_st.rvalid = i_req.rd;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st <= '{
				route_diff: `RPA_RST_ROUTE_DIFF,
				route_lvl: `RPA_RST_ROUTE_LVL,
				bias: `RPA_RST_BIAS,
				agc_en: `RPA_RST_AGC_EN,
				target: `RPA_RST_TARGET,
				attack: `RPA_RST_ATTACK,
				decay: `RPA_RST_DECAY,
				max_gain: `RPA_RST_MAXG,
				max_rsvd: `RPA_RST_MAXG_RSVD,
				hyst: `RPA_RST_HYST,
				noise_thr: `RPA_RST_NOISE,
				clip_step: `RPA_RST_CLIP,
				rdata: 8'h00,
				rvalid: 1'b0
			};
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog controls follow the stored fields directly, except the route level, which is decoded into connected and atten_steps
	always_comb begin
		o_route.differential = st.route_diff;
		o_route.connected = level_connects(st.route_lvl);
		o_route.atten_steps = level_connects(st.route_lvl) ? st.route_lvl : 4'h0;
		o_mic_bias = rpa_pkg::rpa_bias_t'(st.bias);
		o_agc_cfg.enable = st.agc_en;
		o_agc_cfg.target = st.target;
		o_agc_cfg.attack = st.attack;
		o_agc_cfg.decay = st.decay;
		o_agc_cfg.max_gain = st.max_gain;
		o_agc_cfg.hyst = st.hyst;
		o_agc_cfg.noise_thr = st.noise_thr;
		o_agc_cfg.clip_step = st.clip_step;
	end

	assign o_rdata = st.rdata;
	assign o_rvalid = st.rvalid;

	////////////////////////////////////////////////////////////////////////////////
	rpa_agc_core #(
		.P_CYCLES_PER_MS(P_CYCLES_PER_MS)
	) u_agc (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_cfg(o_agc_cfg),
		.i_double_rate_audio(i_double_rate_audio),
		.i_level_valid(i_level_valid),
		.i_level_atten(i_level_atten),
		.i_clip(i_clip),
		.o_gain(o_agc_gain),
		.o_gated(o_agc_gated)
	);

endmodule : rpa_regs

// ### bench/rpa_regs_sva.sv
// concurrent checks on the ports of the record path register bank
`timescale 1ns/1ps

module rpa_regs_sva (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// register port
	input wire rpa_pkg::rpa_reg_req_t i_req,
	input wire logic [7:0] o_rdata,
	input wire logic o_rvalid,
	// controls
	input wire rpa_pkg::rpa_route_t o_route,
	input wire rpa_pkg::rpa_bias_t o_mic_bias,
	input wire rpa_pkg::rpa_agc_cfg_t o_agc_cfg,
	input wire logic [6:0] o_agc_gain,
	input wire logic o_agc_gated
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	logic wr_route;
	logic [6:0] cap;
	assign wr_route = i_req.wr && i_req.addr == 7'h18;
	assign cap = (o_agc_cfg.max_gain > 7'h77) ? 7'h77 : o_agc_cfg.max_gain;
	//////////////////////////////////////////////////////////////////////////
	chk_read_answer: assert property (i_req.rd |=> o_rvalid)
		else $error("read not answered");
	chk_no_stray: assert property (!i_req.rd |=> !o_rvalid)
		else $error("answer without read");
	chk_route_level: assert property (wr_route && i_req.wdata[6:3] <= 4'h8 |=>
		o_route.connected && o_route.atten_steps == $past(i_req.wdata[6:3]))
		else $error("input level not applied");
	chk_route_off: assert property (wr_route && i_req.wdata[6:3] > 4'h8 |=>
		!o_route.connected && o_route.atten_steps == 4'h0)
		else $error("input not disconnected");
	chk_diff_mode: assert property (wr_route |=>
		o_route.differential == $past(i_req.wdata[7]))
		else $error("input mode wrong");
	chk_bias_level: assert property (i_req.wr && i_req.addr == 7'h19 |=>
		o_mic_bias == $past(i_req.wdata[7:6]))
		else $error("bias level wrong");
	chk_agc_fields: assert property (i_req.wr && i_req.addr == 7'h1A |=>
		{o_agc_cfg.enable, o_agc_cfg.target, o_agc_cfg.attack, o_agc_cfg.decay}
		== $past(i_req.wdata))
		else $error("gain control fields wrong");
	chk_max_field: assert property (i_req.wr && i_req.addr == 7'h1B |=>
		o_agc_cfg.max_gain == $past(i_req.wdata[7:1]))
		else $error("max gain field wrong");
	chk_gate_fields: assert property (i_req.wr && i_req.addr == 7'h1C |=>
		{o_agc_cfg.hyst, o_agc_cfg.noise_thr, o_agc_cfg.clip_step} == $past(i_req.wdata))
		else $error("noise gate fields wrong");
	chk_route_rsvd: assert property (i_req.rd && i_req.addr == 7'h18 |=>
		o_rdata[2:0] == 3'h0)
		else $error("route reserved bits set");
	chk_bias_rsvd: assert property (i_req.rd && i_req.addr == 7'h19 |=>
		o_rdata[5:0] == 6'h00)
		else $error("bias reserved bits set");
	chk_gain_capped: assert property (o_agc_cfg.enable && $stable(o_agc_cfg.max_gain) |->
		o_agc_gain <= cap)
		else $error("gain above maximum");
	chk_gain_idle: assert property (!o_agc_cfg.enable |=> o_agc_gain == 7'h00)
		else $error("gain while disabled");
	chk_gate_hold: assert property (o_agc_gated |=> o_agc_gain <= $past(o_agc_gain))
		else $error("gain rose while gated");
	c_read: cover property (i_req.rd ##1 o_rvalid);
	c_connect: cover property (wr_route ##1 o_route.connected);
	c_gain_cap: cover property (o_agc_cfg.enable && o_agc_gain == cap && cap != 7'h00);
	c_gated: cover property (o_agc_gated ##1 !o_agc_gated);
endmodule : rpa_regs_sva

// ### bench/rpa_regs_test.sv
// self-checking bench of the record path register bank
`timescale 1ns/1ps

module rpa_regs_test;
	logic i_clock;
	logic i_rst;
	rpa_pkg::rpa_reg_req_t i_req;
	logic [7:0] o_rdata;
	logic o_rvalid;
	logic i_double_rate_audio;
	logic i_level_valid;
	logic [7:0] i_level_atten;
	logic i_clip;
	rpa_pkg::rpa_route_t o_route;
	rpa_pkg::rpa_bias_t o_mic_bias;
	rpa_pkg::rpa_agc_cfg_t o_agc_cfg;
	logic [6:0] o_agc_gain;
	logic o_agc_gated;
	int n_fail;
	int checks_done;
	int seed;
	logic [7:0] img [0:4];
	logic [7:0] d;
	logic [6:0] a;

	rpa_regs #(.P_CYCLES_PER_MS(64)) i_rpa_regs (.i_clock(i_clock), .i_rst(i_rst),
		.i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.i_double_rate_audio(i_double_rate_audio), .i_level_valid(i_level_valid),
		.i_level_atten(i_level_atten), .i_clip(i_clip), .o_route(o_route),
		.o_mic_bias(o_mic_bias), .o_agc_cfg(o_agc_cfg), .o_agc_gain(o_agc_gain),
		.o_agc_gated(o_agc_gated));

	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_rd

	task automatic cmp_cfg(input logic [30:0] got, input logic [30:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_cfg

	function automatic logic [7:0] msk(input logic [6:0] a);
		return (a == 7'h18) ? 8'hF8 : (a == 7'h19) ? 8'hC0 : 8'hFF;
	endfunction : msk

	// route, bias and gain control fields expected from the register image
	function automatic logic [30:0] exp_out();
		logic [3:0] l;
		l = img[0][6:3];
		return {img[0][7], l <= 4'h8, (l <= 4'h8) ? l : 4'h0, img[1][7:6], img[2],
			img[3][7:1], img[4]};
	endfunction : exp_out

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(negedge i_clock);
		i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge i_clock);
		i_req.wr = 1'b0;
		if (a >= 7'h18 && a <= 7'h1C)
			img[a - 7'h18] = v & msk(a);
		cmp_cfg({o_route, o_mic_bias, o_agc_cfg}, exp_out());
	endtask : wr

	task automatic rd(input logic [6:0] a);
		@(negedge i_clock);
		i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge i_clock);
		i_req.rd = 1'b0;
		cmp_rd({7'h00, o_rvalid}, 8'h01);
		cmp_rd(o_rdata, (a >= 7'h18 && a <= 7'h1C) ? img[a - 7'h18] : 8'h00);
	endtask : rd

	task automatic results();
		$display("comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	//////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 45947;
		n_fail = 0;
		checks_done = 0;
		i_rst = 1'b1;
		i_req = '0;
		i_double_rate_audio = 1'b0;
		i_level_valid = 1'b0;
		i_level_atten = 8'hFF;
		i_clip = 1'b0;
		img = '{8'h78, 8'h00, 8'h00, 8'hFE, 8'h00};
		repeat (4) @(negedge i_clock);
		i_rst = 1'b0;
		cmp_cfg({o_route, o_mic_bias, o_agc_cfg}, exp_out());
		for (int k = 0; k < 5; k++)
			rd(7'h18 + 7'(k));
		for (int k = 0; k < 16; k++)
			if (k < 9 || k == 15)
				wr(7'h18, {1'(k), 4'(k), 3'h0});
		for (int k = 0; k < 4; k++)
			wr(7'h19, {2'(k), 6'h00});
		wr(7'h1D, 8'hFF);
		rd(7'h1D);
		rd(7'h17);
		for (int k = 0; k < 80; k++) begin
			a = 7'h18 + 7'($unsigned($random(seed)) % 5);
			d = 8'($random(seed));
			if (a == 7'h18 && d[6:3] > 4'h8 && d[6:3] < 4'hF)
				d[6:3] = 4'hF;
			d = d & msk(a);
			if (a == 7'h1B)
				d[0] = 1'b0;
			wr(a, d);
			rd(a);
		end
		// quiet input: gain climbs to the programmed maximum and stops there
		wr(7'h1C, 8'h00);
		wr(7'h1B, 8'h0A);
		i_level_valid = 1'b1;
		i_level_atten = 8'h40;
		wr(7'h1A, 8'h80);
		repeat (700) @(negedge i_clock);
		cmp_rd({1'b0, o_agc_gain}, 8'h05);
		wr(7'h1B, 8'h04);
		repeat (3) @(negedge i_clock);
		cmp_rd({1'b0, o_agc_gain}, 8'h02);
		// disabling drops the gain on the next cycle; enabling again climbs one step per 100
		wr(7'h1A, 8'h00);
		@(negedge i_clock);
		cmp_rd({1'b0, o_agc_gain}, 8'h00);
		wr(7'h1A, 8'h80);
		repeat (150) @(negedge i_clock);
		cmp_rd({1'b0, o_agc_gain}, 8'h01);
		repeat (100) @(negedge i_clock);
		cmp_rd({1'b0, o_agc_gain}, 8'h02);
		// noise gate holds the gain, clip stepping still lowers it, hysteresis delays release
		wr(7'h1C, 8'h03);
		repeat (2) @(negedge i_clock);
		cmp_rd({7'h00, o_agc_gated}, 8'h01);
		i_clip = 1'b1;
		@(negedge i_clock);
		i_clip = 1'b0;
		cmp_rd({1'b0, o_agc_gain}, 8'h01);
		i_level_atten = 8'h3B;
		repeat (3) @(negedge i_clock);
		cmp_rd({7'h00, o_agc_gated}, 8'h01);
		i_level_atten = 8'h39;
		repeat (3) @(negedge i_clock);
		cmp_rd({7'h00, o_agc_gated}, 8'h00);
		// loud input with double rate: gain falls to zero at the attack rate
		i_level_atten = 8'h00;
		i_double_rate_audio = 1'b1;
		repeat (60) @(negedge i_clock);
		cmp_rd({1'b0, o_agc_gain}, 8'h00);
		results();
	end

	initial begin
		repeat (5000) @(posedge i_clock);
		n_fail++;
		results();
	end
endmodule : rpa_regs_test

bind rpa_regs rpa_regs_sva i_rpa_regs_sva (.i_clock(i_clock), .i_rst(i_rst), .i_req(i_req),
	.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_route(o_route), .o_mic_bias(o_mic_bias),
	.o_agc_cfg(o_agc_cfg), .o_agc_gain(o_agc_gain), .o_agc_gated(o_agc_gated));
